// ==== scr_pkg.sv ====
// package of register offsets, field positions, resets and carrier types for the channel bank
package scr_pkg;

   // ****************************************
   // register offsets
   // ****************************************
   localparam logic [7:0] SCR_ADDR_CH8_OUT  = 8'h4f;
   localparam logic [7:0] SCR_ADDR_CH8_TERM = 8'h50;
   localparam logic [7:0] SCR_ADDR_CH9_OUT  = 8'h51;
   localparam logic [7:0] SCR_ADDR_CH9_TERM = 8'h52;
   localparam logic [7:0] SCR_ADDR_DIVA_LO  = 8'h53;
   localparam logic [7:0] SCR_ADDR_DIVAB    = 8'h54;
   localparam logic [7:0] SCR_ADDR_DIVB_HI  = 8'h55;

   // ****************************************
   // reset values
   // ****************************************
   localparam logic [7:0] SCR_RST_DIVA_LO = 8'h40;
   localparam logic [7:0] SCR_RST_ZERO    = 8'h00;

   // ****************************************
   // field positions and channel count
   // ****************************************
   localparam int SCR_B_DIV_CHOICE = 7;
   localparam int SCR_B_DRIVE      = 6;
   localparam int SCR_CM_MSB       = 5;
   localparam int SCR_B_AUTO_SLEEP = 7;
   localparam int SCR_B_RX_UNGND   = 5;
   localparam int SCR_B_TX_UNGND   = 4;
   localparam int SCR_B_RX_SHORT   = 3;
   localparam int SCR_B_TX_SHORT   = 2;
   localparam int SCR_B_CAP_COUPLE = 1;
   localparam int SCR_NUM_CH       = 2;

   // per-channel settings toward the analog driver and receiver
   typedef struct packed {
      logic       use_ratio_b;   // 0 ratio a, 1 ratio b
      logic       drive_high;    // 0 low current, 1 high current
      logic [5:0] cm_code;       // common-mode resistor code
      logic       rx_powered;    // receiver power enable
      logic       rx_unground;
      logic       tx_unground;
      logic       rx_term_short;
      logic       tx_term_short;
      logic       rx_cap_coupling;
   } scr_ch_cfg_t;

endpackage : scr_pkg

// ==== scr_sync_channel_regs.sv ====
// register bank for sync channels 8 and 9 and the shared output divide ratios
//
// The address-and-strobe port was left to the implementer.
`timescale 1ns/1ps
module scr_sync_channel_regs
   import scr_pkg::*;
(
   input  wire logic              clk_i,
   input  wire logic              resetn_i,
   input  wire logic [7:0]        addr_i,
   input  wire logic [7:0]        wdata_i,
   input  wire logic              wr_i,
   input  wire logic              rd_i,
   input  wire logic [1:0]        measure_use_i,   // measure unit uses ch8 [0], ch9 [1]
   output logic      [7:0]        rdata_o,
   output scr_ch_cfg_t            ch8_cfg_o,
   output scr_ch_cfg_t            ch9_cfg_o,
   output logic      [11:0]       ch8_ratio_o,     // divide ratio applied to ch8
   output logic      [11:0]       ch9_ratio_o,     // divide ratio applied to ch9
   output logic      [11:0]       shared_ratio_a_o,
   output logic      [11:0]       shared_ratio_b_o
);

   // ****************************************
   // usage notes
   // ****************************************
   // channel 8 sits at index 0 and channel 9 at index 1 of every per-channel array
   // outputs lag a register write by two edges: byte register first, then output flop
   // the shared ratios span three bytes that software writes one at a time;
   // between those writes a channel briefly runs on a half-updated ratio
   // ratios below ten are not trapped here; keeping them legal is the software's job
   // receiver power follows the measure unit's channel use one edge late
   // unmapped offsets read as zero and ignore writes
   // the bus never stalls: a strobe is taken on the edge where it stands

   // ****************************************
   // local constants
   // ****************************************
   // settings at reset: all other fields clear, receiver powered since auto-sleep resets clear
   localparam scr_ch_cfg_t CFG_RST     = '{rx_powered: 1'b1, default: '0};
   // ratio a leaves reset through its low byte default, upper nibble clear
   localparam logic [11:0] RATIO_A_RST = {SCR_RST_ZERO[3:0], SCR_RST_DIVA_LO};
   // ratio b leaves reset at zero
   localparam logic [11:0] RATIO_B_RST = {SCR_RST_ZERO, SCR_RST_ZERO[3:0]};

   // ****************************************
   // register storage
   // ****************************************
   // per-channel output configuration bytes
   logic [7:0] out_reg  [SCR_NUM_CH];
   logic [7:0] out_next [SCR_NUM_CH];
   // per-channel receiver and termination bytes
   logic [7:0] term_reg  [SCR_NUM_CH];
   logic [7:0] term_next [SCR_NUM_CH];
   // shared divide ratio bytes
   logic [7:0] diva_lo_reg, diva_lo_next;
   logic [7:0] divab_reg,   divab_next;
   logic [7:0] divb_hi_reg, divb_hi_next;
   // read data, zero except in the cycle after a read strobe
   logic [7:0] rdata_reg,   rdata_next;

   // ****************************************
   // derived state toward the analog side
   // ****************************************
   // decoded channel settings, registered so every output comes from a flop
   scr_ch_cfg_t cfg_reg  [SCR_NUM_CH];
   scr_ch_cfg_t cfg_next [SCR_NUM_CH];
   // ratio applied to each channel after the a or b choice
   logic [11:0] ratio_reg  [SCR_NUM_CH];
   logic [11:0] ratio_next [SCR_NUM_CH];
   // registered copies of the shared ratios
   logic [11:0] ra_reg, ra_next;
   logic [11:0] rb_reg, rb_next;
   // shared ratios assembled from the stored bytes, before registering
   logic [11:0] ra_cur, rb_cur;

   // ****************************************
   // decode helpers
   // ****************************************
   // address match of one strobe against one register offset
   function automatic logic hit(input logic       strobe,
                                input logic [7:0] addr,
                                input logic [7:0] target);
      return strobe && (addr == target);
   endfunction

   // next value of a byte register: the written byte on a hit, else hold
   function automatic logic [7:0] next_byte(input logic       strobe,
                                            input logic [7:0] addr,
                                            input logic [7:0] target,
                                            input logic [7:0] wdata,
                                            input logic [7:0] cur);
      return hit(strobe, addr, target) ? wdata : cur;
   endfunction

   // offset of a channel's output configuration register
   function automatic logic [7:0] out_addr(input int ch);
      return (ch == 0) ? SCR_ADDR_CH8_OUT : SCR_ADDR_CH9_OUT;
   endfunction

   // offset of a channel's receiver and termination register
   function automatic logic [7:0] term_addr(input int ch);
      return (ch == 0) ? SCR_ADDR_CH8_TERM : SCR_ADDR_CH9_TERM;
   endfunction

   // ratio a channel runs on, from its divider-choice bit
   function automatic logic [11:0] pick_ratio(input logic        choose_b,
                                              input logic [11:0] ratio_a,
                                              input logic [11:0] ratio_b);
      return choose_b ? ratio_b : ratio_a;
   endfunction

   // ****************************************
   // per-channel logic
   // ****************************************
   // both channels share one layout, so the same logic is laid down per index
   genvar g;
   generate
      for (g = 0; g < SCR_NUM_CH; g++) begin : gen_ch

         // write decode: a write replaces the whole byte, reserved bits included
         always_comb begin
            out_next[g]  = next_byte(wr_i, addr_i, out_addr(g), wdata_i, out_reg[g]);
            term_next[g] = next_byte(wr_i, addr_i, term_addr(g), wdata_i,
                                     term_reg[g]);   // reserved bits stored
         end

         // channel byte registers
         always_ff @(posedge clk_i or negedge resetn_i) begin
            if (!resetn_i) begin
               out_reg[g]  <= SCR_RST_ZERO;
               term_reg[g] <= SCR_RST_ZERO;
            end else begin
               out_reg[g]  <= out_next[g];
               term_reg[g] <= term_next[g];
            end
         end

         // field decode toward the driver and receiver
         always_comb begin
            cfg_next[g].use_ratio_b     = out_reg[g][SCR_B_DIV_CHOICE];
            cfg_next[g].drive_high      = out_reg[g][SCR_B_DRIVE];
            cfg_next[g].cm_code         = out_reg[g][SCR_CM_MSB:0];
            // receiver stays on unless auto-sleep is set and the measure unit is elsewhere
            cfg_next[g].rx_powered      = !term_reg[g][SCR_B_AUTO_SLEEP]
                                          || measure_use_i[g];
            cfg_next[g].rx_unground     = term_reg[g][SCR_B_RX_UNGND];
            cfg_next[g].tx_unground     = term_reg[g][SCR_B_TX_UNGND];
            cfg_next[g].rx_term_short   = term_reg[g][SCR_B_RX_SHORT];
            cfg_next[g].tx_term_short   = term_reg[g][SCR_B_TX_SHORT];
            cfg_next[g].rx_cap_coupling = term_reg[g][SCR_B_CAP_COUPLE];
            ratio_next[g] = pick_ratio(out_reg[g][SCR_B_DIV_CHOICE],
                                       ra_cur, rb_cur);
         end

         // registered settings, one flop stage so the analog side sees no glitch
         always_ff @(posedge clk_i or negedge resetn_i) begin
            if (!resetn_i) begin
               cfg_reg[g]   <= CFG_RST;       // auto-sleep clear at reset
               ratio_reg[g] <= RATIO_A_RST;   // choice bit clear, so ratio a
            end else begin
               cfg_reg[g]   <= cfg_next[g];
               ratio_reg[g] <= ratio_next[g];
            end
         end

      end
   endgenerate

   // ****************************************
   // shared divide ratio bytes
   // ****************************************
   // each byte takes effect on its own; there is no atomic update across bytes
   always_comb begin
      diva_lo_next = next_byte(wr_i, addr_i, SCR_ADDR_DIVA_LO, wdata_i, diva_lo_reg);
      divab_next   = next_byte(wr_i, addr_i, SCR_ADDR_DIVAB, wdata_i, divab_reg);
      divb_hi_next = next_byte(wr_i, addr_i, SCR_ADDR_DIVB_HI, wdata_i, divb_hi_reg);
   end

   // divider byte registers
   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         diva_lo_reg <= SCR_RST_DIVA_LO;
         divab_reg   <= SCR_RST_ZERO;
         divb_hi_reg <= SCR_RST_ZERO;
      end else begin
         diva_lo_reg <= diva_lo_next;
         divab_reg   <= divab_next;
         divb_hi_reg <= divb_hi_next;
      end
   end

   // ****************************************
   // shared ratio assembly
   // ****************************************
   // the stored value is the ratio itself, no offset or scaling
   always_comb begin
      ra_cur  = {divab_reg[3:0], diva_lo_reg};
      rb_cur  = {divb_hi_reg, divab_reg[7:4]};
      ra_next = ra_cur;
      rb_next = rb_cur;
   end

   // registered copies of the shared ratios
   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         ra_reg <= RATIO_A_RST;
         rb_reg <= RATIO_B_RST;
      end else begin
         ra_reg <= ra_next;
         rb_reg <= rb_next;
      end
   end

   // ****************************************
   // read port
   // ****************************************
   // read mux, data valid the cycle after the strobe and zero otherwise
   always_comb begin
      rdata_next = SCR_RST_ZERO;            // unmapped reads return zero
      if (rd_i) begin
         case (addr_i)
            SCR_ADDR_CH8_OUT:  rdata_next = out_reg[0];
            SCR_ADDR_CH8_TERM: rdata_next = term_reg[0];
            SCR_ADDR_CH9_OUT:  rdata_next = out_reg[1];
            SCR_ADDR_CH9_TERM: rdata_next = term_reg[1];
            SCR_ADDR_DIVA_LO:  rdata_next = diva_lo_reg;
            SCR_ADDR_DIVAB:    rdata_next = divab_reg;
            SCR_ADDR_DIVB_HI:  rdata_next = divb_hi_reg;
            default:           rdata_next = SCR_RST_ZERO;
         endcase
      end
   end

   // read data register
   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         rdata_reg <= SCR_RST_ZERO;
      end else begin
         rdata_reg <= rdata_next;
      end
   end

   // ****************************************
   // outputs
   // ****************************************
   // outputs straight from flip-flops
   assign rdata_o          = rdata_reg;
   assign ch8_cfg_o        = cfg_reg[0];
   assign ch9_cfg_o        = cfg_reg[1];
   assign ch8_ratio_o      = ratio_reg[0];
   assign ch9_ratio_o      = ratio_reg[1];
   assign shared_ratio_a_o = ra_reg;
   assign shared_ratio_b_o = rb_reg;

endmodule // scr_sync_channel_regs

// ==== scr_regs_asserts.sv ====
// assertion checker for the sync channel register bank
`timescale 1ns/1ps
module scr_regs_asserts
   import scr_pkg::*;
(
   input wire logic        clk_i,
   input wire logic        resetn_i,
   input wire logic [7:0]  addr_i,
   input wire logic [7:0]  wdata_i,
   input wire logic        wr_i,
   input wire logic        rd_i,
   input wire logic [1:0]  measure_use_i,
   input wire logic [7:0]  rdata_o,
   input scr_ch_cfg_t      ch8_cfg_o,
   input scr_ch_cfg_t      ch9_cfg_o,
   input wire logic [11:0] ch8_ratio_o,
   input wire logic [11:0] ch9_ratio_o,
   input wire logic [11:0] shared_ratio_a_o,
   input wire logic [11:0] shared_ratio_b_o
);
   default clocking @(posedge clk_i); endclocking
   default disable iff (!resetn_i);
   // ****************************************
   // named steps
   // ****************************************
   sequence wr_to(logic [7:0] a);
      wr_i && addr_i == a;
   endsequence
   // ****************************************
   // assertions
   // ****************************************
   ch8_out_a: assert property (wr_to(SCR_ADDR_CH8_OUT) |-> ##2
      ch8_cfg_o[13:6] == $past(wdata_i, 2)) else $error("ch8 output fields wrong");
   ch9_term_a: assert property (wr_to(SCR_ADDR_CH9_TERM) |-> ##2
      ch9_cfg_o[4:0] == $past(wdata_i[5:1], 2)) else $error("ch9 termination wrong");
   ratio_a_lo_a: assert property (wr_to(SCR_ADDR_DIVA_LO) |-> ##2
      shared_ratio_a_o[7:0] == $past(wdata_i, 2)) else $error("ratio a low wrong");
   ratio_mid_a: assert property (wr_to(SCR_ADDR_DIVAB) |-> ##2
      {shared_ratio_b_o[3:0], shared_ratio_a_o[11:8]} == $past(wdata_i, 2))
      else $error("shared ratio byte wrong");
   ratio_b_hi_a: assert property (wr_to(SCR_ADDR_DIVB_HI) |-> ##2
      shared_ratio_b_o[11:4] == $past(wdata_i, 2)) else $error("ratio b high wrong");
   ch8_route_a: assert property (ch8_ratio_o ==
      (ch8_cfg_o.use_ratio_b ? shared_ratio_b_o : shared_ratio_a_o))
      else $error("ch8 ratio routing wrong");
   rx_wake_a: assert property (measure_use_i[1] |=> ch9_cfg_o.rx_powered)
      else $error("ch9 receiver not powered");
   rx_sleep_a: assert property (wr_to(SCR_ADDR_CH8_TERM) ##1 !measure_use_i[0]
      |=> ch8_cfg_o.rx_powered != $past(wdata_i[7], 2)) else $error("ch8 power wrong");
   ratio_read_a: assert property (rd_i && addr_i == SCR_ADDR_DIVA_LO
      |=> rdata_o == shared_ratio_a_o[7:0]) else $error("ratio a readback differs");
endmodule // scr_regs_asserts

bind scr_sync_channel_regs scr_regs_asserts scr_regs_asserts_i (.clk_i, .resetn_i,
   .addr_i, .wdata_i, .wr_i, .rd_i, .measure_use_i, .rdata_o, .ch8_cfg_o, .ch9_cfg_o,
   .ch8_ratio_o, .ch9_ratio_o, .shared_ratio_a_o, .shared_ratio_b_o);

// ==== tb_top.sv ====
// self-checking bench for the sync channel register bank
`timescale 1ns/1ps
module tb_top;
   import scr_pkg::*;
   logic        clk_i = 1'b0;
   logic        resetn_i = 1'b0;
   logic [7:0]  addr_i = 8'h00;
   logic [7:0]  wdata_i = 8'h00;
   logic        wr_i = 1'b0;
   logic        rd_i = 1'b0;
   logic [1:0]  measure_use_i = 2'h0;
   logic [7:0]  rdata_o;
   logic [7:0]  rv;
   scr_ch_cfg_t ch8_cfg_o, ch9_cfg_o;
   logic [11:0] ch8_ratio_o, ch9_ratio_o, ratio_a_o, ratio_b_o;
   int          err_total = 0;
   int          n_checks = 0;
   int          cyc = 0;
   // rows of address, written byte, byte read back; ratios end at 10 or above, ratio b is below ten until the last divider byte
   logic [23:0] rows [9] = '{24'h4f_c5_c5, 24'h50_7f_7f, 24'h51_3a_3a,
      24'h52_be_be, 24'h53_19_19, 24'h54_90_90, 24'h55_02_02,
      24'h56_ff_00, 24'h4e_ff_00};
   scr_sync_channel_regs scr_sync_channel_regs_i (.clk_i, .resetn_i, .addr_i, .wdata_i,
      .wr_i, .rd_i, .measure_use_i, .rdata_o, .ch8_cfg_o, .ch9_cfg_o, .ch8_ratio_o,
      .ch9_ratio_o, .shared_ratio_a_o(ratio_a_o), .shared_ratio_b_o(ratio_b_o));
   // ****************************************
   // clock, timeout and helpers
   // ****************************************
   initial begin
      forever #2 clk_i = ~clk_i;
   end
   always @(posedge clk_i) begin
      cyc++;
      if (cyc == 1000) begin
         err_total++;
         close_out();
      end
   end
   task automatic close_out();
      $display("checks %0d mismatches %0d", n_checks, err_total);
      if (err_total == 0 && n_checks > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   task automatic check(string nm, logic [15:0] seen, logic [15:0] exp);
      n_checks++;
      if (seen !== exp) begin
         err_total++;
         $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   // one-cycle write strobe
   task automatic wr(logic [7:0] a, logic [7:0] d);
      wr_i <= 1'b1;
      addr_i <= a;
      wdata_i <= d;
      @(posedge clk_i);
      wr_i <= 1'b0;
   endtask
   // one-cycle read strobe, data taken in the following cycle
   task automatic rd(logic [7:0] a);
      rd_i <= 1'b1;
      addr_i <= a;
      @(posedge clk_i);
      rd_i <= 1'b0;
      #1 rv = rdata_o;
      @(posedge clk_i);
   endtask
   // reset for ten cycles, then read back every register
   task automatic do_reset();
      resetn_i <= 1'b0;
      repeat (10) @(posedge clk_i);
      check("reset ratio a", ratio_a_o, 12'h040);
      check("reset ratio b", ratio_b_o, 12'h000);
      check("reset ch8 cfg", ch8_cfg_o, 16'h0020);
      resetn_i <= 1'b1;
      @(posedge clk_i);
      for (logic [7:0] a = 8'h4f; a <= 8'h55; a++) begin
         rd(a);
         check("reset value", rv, (a == 8'h53) ? 8'h40 : 8'h00);
      end
   endtask
   // ****************************************
   // main sequence
   // ****************************************
   initial begin
      do_reset();
      for (int i = 0; i < 9; i++) begin
         wr(rows[i][23:16], rows[i][15:8]);
         rd(rows[i][23:16]);
         check("readback", rv, rows[i][7:0]);
      end
      check("ch8 cfg", ch8_cfg_o, {8'hc5, 1'b1, 5'h1f});
      check("ch9 cfg", ch9_cfg_o, {8'h3a, 1'b0, 5'h1f});
      check("ratio a", ratio_a_o, 12'h019);
      check("ratio b", ratio_b_o, 12'h029);
      check("ch8 ratio", ch8_ratio_o, 12'h029);
      check("ch9 ratio", ch9_ratio_o, 12'h019);
      #1 check("read data drop", rdata_o, 8'h00);
      @(posedge clk_i);
      measure_use_i <= 2'b10;
      wr(SCR_ADDR_CH8_TERM, 8'h80);
      repeat (2) @(posedge clk_i);
      #1 check("ch8 asleep", ch8_cfg_o.rx_powered, 1'b0);
      check("ch9 awake", ch9_cfg_o.rx_powered, 1'b1);
      @(posedge clk_i);
      measure_use_i <= 2'b01;
      repeat (2) @(posedge clk_i);
      #1 check("ch8 woken", ch8_cfg_o.rx_powered, 1'b1);
      @(posedge clk_i);
      do_reset();
      close_out();
   end
endmodule // tb_top
